// ==== rtl/iflow_pkg.sv ====
package iflow_pkg;

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam int COUNT_W = 14;
  localparam logic [7:0] ADDR_REPEAT_COUNT = 8'h00;
  localparam logic [7:0] ADDR_STATUS_LOW = 8'h04;
  localparam logic [7:0] ADDR_FLOW_STATUS = 8'h08;
  localparam int RA_BIT = 4;
  localparam int FLOW_BUSY_BIT = 1;
  localparam int FLOW_PSV_BIT = 2;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 14'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 14'h0001;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam int RETURN_CYCLES = 3;
  localparam int TABLE_CYCLES = 2;
  localparam int TWO_WORD_CYCLES = 2;
  localparam int PSV_FIRST_CYCLES = 2;

  // ----------------------------------------
  // Bus encodings
  // ----------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    IC_NORMAL,
    IC_RETURN,
    IC_RET_LIT,
    IC_INT_RETURN,
    IC_TABLE,
    IC_TWO_WORD,
    IC_SECOND_WORD,
    IC_REPEAT_LIT,
    IC_REPEAT_REG
  } iflow_iclass_t;

  typedef struct packed {
    logic valid;
    iflow_iclass_t iclass;
    logic [COUNT_W-1:0] literal;
    logic [15:0] work_reg;
    logic psv_read;
    logic addr_dep;
  } iflow_decode_t;

  typedef struct packed {
    logic fetch_enable;
    logic pc_increment;
    logic flush_prefetch;
    logic hold_fetched;
    logic exec_as_nop;
    logic progmem_access;
    logic stall;
    logic busy;
  } iflow_ctl_t;

endpackage : iflow_pkg

// ==== rtl/iflow_repeat_unit.sv ====
`timescale 1ns/1ps
module iflow_repeat_unit (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n_sync,
  // Load and update
  input wire logic load,
  input wire logic [iflow_pkg::COUNT_W-1:0] load_value,
  input wire logic sw_write,
  input wire logic [iflow_pkg::COUNT_W-1:0] sw_value,
  input wire logic decrement,
  input wire logic exc_clear,
  input wire logic restore,
  input wire logic restore_flag,
  // State
  output logic [iflow_pkg::COUNT_W-1:0] count,
  output logic active
);

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  logic [iflow_pkg::COUNT_W-1:0] next_count;
  logic [iflow_pkg::COUNT_W-1:0] count_less;
  logic next_active;

  assign count_less = count - iflow_pkg::COUNT_ONE;
  // Instruction load beats a bus write, which beats the per-iteration step
  assign next_count = load ? load_value :
                      sw_write ? sw_value :
                      (decrement && count != iflow_pkg::COUNT_RESET) ? count_less :
                      count;
  assign next_active = load ? (load_value != iflow_pkg::COUNT_RESET) :
                       restore ? (restore_flag && next_count != iflow_pkg::COUNT_RESET) :
                       exc_clear ? 1'b0 :
                       decrement ? (next_count != iflow_pkg::COUNT_RESET) :
                       active;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      count <= iflow_pkg::COUNT_RESET;
      active <= 1'b0;
    end else begin
      count <= next_count;
      active <= next_active;
    end
  end

endmodule : iflow_repeat_unit

// ==== rtl/iflow_sequencer.sv ====
`timescale 1ns/1ps
module iflow_sequencer (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Instruction in the execute slot
  input wire iflow_pkg::iflow_decode_t dec,
  // Exception entry and status stack
  input wire logic exc_entry,
  input wire logic [7:0] stack_status_in,
  output logic [7:0] stacked_status,
  // Pipeline control
  output iflow_pkg::iflow_ctl_t ctl,
  // Repeat state
  output logic [iflow_pkg::COUNT_W-1:0] repeat_loop_count,
  output logic repeat_active_flag,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_n_sync;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n_sync <= rst_meta;
    end
  end

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic is_return(input iflow_pkg::iflow_iclass_t ic);
    is_return = (ic == iflow_pkg::IC_RETURN) || (ic == iflow_pkg::IC_RET_LIT) ||
                (ic == iflow_pkg::IC_INT_RETURN);
  endfunction : is_return

  function automatic logic is_repeat(input iflow_pkg::iflow_iclass_t ic);
    is_repeat = (ic == iflow_pkg::IC_REPEAT_LIT) || (ic == iflow_pkg::IC_REPEAT_REG);
  endfunction : is_repeat

  typedef enum logic [2:0] {
    S_RUN,
    S_RET2,
    S_RET3,
    S_TABLE,
    S_OPERAND,
    S_STALL
  } iflow_state_t;

  iflow_state_t state;
  iflow_state_t next_state;
  iflow_pkg::iflow_ctl_t next_ctl;
  logic ret_is_int;
  logic psv_first;
  logic [7:0] status_store;
  logic [7:0] status_view;

  wire run = (state == S_RUN);
  wire take_exc = run && exc_entry;
  wire take = run && dec.valid && !exc_entry;
  wire take_ret = take && is_return(dec.iclass);
  wire take_tbl = take && dec.iclass == iflow_pkg::IC_TABLE;
  wire take_two = take && dec.iclass == iflow_pkg::IC_TWO_WORD;
  wire take_orphan = take && dec.iclass == iflow_pkg::IC_SECOND_WORD;
  wire take_rep = take && is_repeat(dec.iclass);
  wire plain = take && !take_ret && !take_tbl && !take_two;
  // The first run of a resumed target that reads program space needs a second cycle
  wire psv_extra = psv_first && dec.psv_read;
  wire stall_need = plain && (dec.addr_dep || psv_extra);
  // Restricted targets are never repeated, so any resumed step counts as one iteration
  wire decrement = take && repeat_active_flag && !take_rep;
  wire restore = (state == S_RET3) && ret_is_int;
  wire [iflow_pkg::COUNT_W-1:0] wreg_low = dec.work_reg[iflow_pkg::COUNT_W-1:0];
  wire [iflow_pkg::COUNT_W-1:0] rep_value =
    (dec.iclass == iflow_pkg::IC_REPEAT_LIT) ? dec.literal : wreg_low;
  wire [iflow_pkg::COUNT_W-1:0] count_minus = repeat_loop_count - iflow_pkg::COUNT_ONE;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic wr_pend;
  logic [7:0] wr_addr;
  wire addr_take = hsel && htrans == iflow_pkg::HTRANS_NONSEQ && hready;
  wire wr_count = wr_pend && wr_addr == iflow_pkg::ADDR_REPEAT_COUNT;
  wire wr_status = wr_pend && wr_addr == iflow_pkg::ADDR_STATUS_LOW;
  wire [7:0] bus_addr = haddr[7:0];
  wire [31:0] flow_word = {29'h0000_0000, psv_first, state != S_RUN, repeat_active_flag};
  wire [31:0] rd_word =
    (bus_addr == iflow_pkg::ADDR_REPEAT_COUNT) ? {18'h00000, repeat_loop_count} :
    (bus_addr == iflow_pkg::ADDR_STATUS_LOW) ? {24'h000000, status_view} :
    (bus_addr == iflow_pkg::ADDR_FLOW_STATUS) ? flow_word :
    32'h0000_0000;

  // Read data is picked at the address phase so the data phase answers with no wait
  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= iflow_pkg::HRESP_OKAY;
    end else begin
      wr_pend <= addr_take && hwrite;
      wr_addr <= bus_addr;
      hrdata <= (addr_take && !hwrite) ? rd_word : hrdata;
      hreadyout <= 1'b1;
      hresp <= iflow_pkg::HRESP_OKAY;
    end
  end

  // ----------------------------------------
  // Repeat count and active flag
  // ----------------------------------------
  iflow_repeat_unit u_repeat (
    .clock(clock),
    .rst_n_sync(rst_n_sync),
    .load(take_rep),
    .load_value(rep_value),
    .sw_write(wr_count),
    .sw_value(hwdata[iflow_pkg::COUNT_W-1:0]),
    .decrement(decrement),
    .exc_clear(take_exc),
    .restore(restore),
    .restore_flag(stack_status_in[iflow_pkg::RA_BIT]),
    .count(repeat_loop_count),
    .active(repeat_active_flag)
  );

  // ----------------------------------------
  // Status low byte
  // ----------------------------------------
  // The active bit is read from the repeat unit, not from the store, so a bus write cannot touch it
  assign status_view = {status_store[7:5], repeat_active_flag, status_store[3:0]};

  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      status_store <= iflow_pkg::STATUS_RESET;
      stacked_status <= iflow_pkg::STATUS_RESET;
      ret_is_int <= 1'b0;
      psv_first <= 1'b0;
    end else begin
      if (restore) begin
        status_store <= stack_status_in;
      end else if (wr_status) begin
        status_store <= hwdata[7:0];
      end
      if (take_exc) begin
        stacked_status <= status_view;
      end
      if (take_ret) begin
        ret_is_int <= dec.iclass == iflow_pkg::IC_INT_RETURN;
      end
      if (restore) begin
        psv_first <= stack_status_in[iflow_pkg::RA_BIT];
      end else if (take) begin
        psv_first <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Flow sequencing
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      S_RUN: begin
        if (take_ret) begin
          next_state = S_RET2;
        end else if (take_tbl) begin
          next_state = S_TABLE;
        end else if (take_two) begin
          next_state = S_OPERAND;
        end else if (stall_need) begin
          next_state = S_STALL;
        end else begin
          next_state = S_RUN;
        end
      end
      S_RET2: next_state = S_RET3;
      S_RET3: next_state = S_RUN;
      S_TABLE: next_state = S_RUN;
      S_OPERAND: next_state = S_RUN;
      S_STALL: next_state = S_RUN;
      default: next_state = S_RUN;
    endcase
  end

  // Control for the coming cycle; the loop holds the program counter for each instruction taken while the flag is up
  always_comb begin
    next_ctl = '0;
    next_ctl.fetch_enable = (next_state == S_RUN) || (next_state == S_RET3) ||
                            (next_state == S_OPERAND);
    next_ctl.pc_increment = next_ctl.fetch_enable && !(take && repeat_active_flag);
    next_ctl.flush_prefetch = take_ret;
    next_ctl.hold_fetched = take_tbl;
    next_ctl.progmem_access = take_tbl;
    next_ctl.exec_as_nop = take_orphan || (take_rep && rep_value == '0);
    next_ctl.stall = stall_need && next_state == S_STALL;
    next_ctl.busy = next_state != S_RUN;
  end

  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state <= S_RUN;
      ctl <= '0;
    end else begin
      state <= next_state;
      ctl <= next_ctl;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n_sync);

  a_return_three_cycles: assert property (
    take_ret |=> ctl.busy && ctl.flush_prefetch ##1 ctl.busy ##1 !ctl.busy
  ) else $error("return did not take three cycles");

  a_return_prefetch: assert property (
    take_ret |=> !ctl.fetch_enable ##1 ctl.fetch_enable
  ) else $error("return third cycle did not prefetch");

  a_table_slot: assert property (
    take_tbl |=> ctl.progmem_access && ctl.hold_fetched && !ctl.fetch_enable ##1 !ctl.busy
  ) else $error("table operation slot wrong");

  a_two_word_op: assert property (
    take_two |=> ctl.busy && ctl.fetch_enable ##1 !ctl.busy
  ) else $error("two-word instruction not two cycles");

  a_orphan_word_nop: assert property (
    take_orphan |=> ctl.exec_as_nop
  ) else $error("orphan second word not a no-operation");

  a_dep_stall_one: assert property (
    (plain && dec.addr_dep) |=> ctl.stall && !ctl.fetch_enable ##1 !ctl.stall
  ) else $error("dependency stall not one cycle");

  a_literal_load: assert property (
    (take && dec.iclass == iflow_pkg::IC_REPEAT_LIT) |=>
      repeat_loop_count == $past(rep_value) &&
      repeat_active_flag == ($past(rep_value) != 14'h0000)
  ) else $error("literal repeat load wrong");

  a_register_low_bits: assert property (
    (take && dec.iclass == iflow_pkg::IC_REPEAT_REG) |=> repeat_loop_count == $past(wreg_low)
  ) else $error("register repeat count not low bits");

  a_count_step: assert property (
    (decrement && !wr_count) |=>
      repeat_loop_count ==
        ($past(repeat_loop_count) == 14'h0000 ? 14'h0000 : $past(count_minus)) &&
      repeat_active_flag == (repeat_loop_count != 14'h0000)
  ) else $error("repeat count did not step");

  a_pc_held: assert property (
    (take && repeat_active_flag) |=> !ctl.pc_increment
  ) else $error("program counter moved during loop");

  a_flag_readonly: assert property (
    (wr_status && !take_rep && !decrement && !take_exc && !restore) |=>
      $stable(repeat_active_flag)
  ) else $error("status write changed active flag");

  a_exc_push_clear: assert property (
    take_exc |=> !repeat_active_flag && stacked_status[4] == $past(repeat_active_flag)
  ) else $error("exception entry did not push and clear");

  a_early_end: assert property (
    (restore && repeat_loop_count == 14'h0000 && !wr_count) |=> !repeat_active_flag
  ) else $error("zeroed count still resumed loop");

  a_resume_loop: assert property (
    (restore && stack_status_in[4] && repeat_loop_count != 14'h0000 && !wr_count) |=>
      repeat_active_flag && psv_first
  ) else $error("interrupt return did not resume loop");

  a_zero_count_nop: assert property (
    (take_rep && rep_value == 14'h0000) |=>
      ctl.exec_as_nop && !repeat_active_flag && repeat_loop_count == 14'h0000
  ) else $error("zero repeat count not a no-operation");

  a_count_source: assert property (
    (take && dec.iclass == iflow_pkg::IC_REPEAT_LIT) |=> repeat_loop_count == $past(dec.literal)
  ) else $error("repeat count not taken from literal");

  a_flag_set_nonzero: assert property (
    (take_rep && rep_value != 14'h0000) |=> repeat_active_flag
  ) else $error("non-zero repeat did not set active flag");

  a_psv_first_stall: assert property (
    (plain && psv_first && dec.psv_read) |=> ctl.stall && ctl.busy ##1 !ctl.busy
  ) else $error("resumed visibility target not two cycles");

  a_final_clear: assert property (
    (decrement && repeat_loop_count == 14'h0001 && !wr_count) |=>
      repeat_loop_count == 14'h0000 && !repeat_active_flag
  ) else $error("final iteration did not clear loop");

  a_pc_resumes: assert property (
    (take && !repeat_active_flag) |=> ctl.pc_increment == ctl.fetch_enable
  ) else $error("program counter held outside loop");

  a_count_readback: assert property (
    (addr_take && !hwrite && bus_addr == iflow_pkg::ADDR_REPEAT_COUNT) |=>
      hrdata == {18'h00000, $past(repeat_loop_count)}
  ) else $error("count register read wrong");

  a_return_pop: assert property (
    (restore && !wr_count) |=>
      repeat_active_flag == ($past(stack_status_in[4]) && repeat_loop_count != 14'h0000)
  ) else $error("interrupt return did not restore flag");

  a_status_write: assert property (
    (wr_status && !restore) |=>
      status_view[3:0] == $past(hwdata[3:0])
  ) else $error("status byte write did not land");

  a_count_write: assert property (
    (wr_count && !take_rep) |=>
      repeat_loop_count == $past(hwdata[iflow_pkg::COUNT_W-1:0])
  ) else $error("count register write did not land");

endmodule : iflow_sequencer

// ==== test/instruction_flow_repeat_loop_tb.sv ====
`timescale 1ns/1ps
module instruction_flow_repeat_loop_tb;
  // ------
  // Design and bench state
  // ------
  localparam logic [31:0] FE = 32'h80;
  localparam logic [31:0] PI = 32'h40;
  localparam logic [31:0] FL = 32'h20;
  localparam logic [31:0] HO = 32'h10;
  localparam logic [31:0] NP = 32'h08;
  localparam logic [31:0] PM = 32'h04;
  localparam logic [31:0] ST = 32'h02;
  localparam logic [31:0] BZ = 32'h01;
  localparam logic [31:0] CM = 32'h3fff;
  typedef struct {
    int cyc;
    int sel;
    logic [31:0] mask;
    logic [31:0] exp;
  } iflow_note_t;
  logic clock;
  logic reset_n;
  iflow_pkg::iflow_decode_t dec;
  logic exc_entry;
  logic [7:0] stack_status_in;
  logic [7:0] stacked_status;
  iflow_pkg::iflow_ctl_t ctl;
  logic [13:0] repeat_loop_count;
  logic repeat_active_flag;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic rd_pend = 1'b0;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int base = 0;
  int cycles = 0;
  logic [31:0] r;
  iflow_note_t tq[$];
  logic [31:0] rdq[$];
  string names[4] = '{"ctl", "count", "flag", "stacked"};
  iflow_pkg::iflow_iclass_t rets[3] = '{iflow_pkg::IC_RETURN, iflow_pkg::IC_RET_LIT,
    iflow_pkg::IC_INT_RETURN};

  assign hready = hreadyout;

  iflow_sequencer dut_u (.clock(clock), .reset_n(reset_n), .dec(dec), .exc_entry(exc_entry),
    .stack_status_in(stack_status_in), .stacked_status(stacked_status), .ctl(ctl),
    .repeat_loop_count(repeat_loop_count), .repeat_active_flag(repeat_active_flag),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ------
  // Tasks
  // ------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    if (tq.size() != 0) errors++;
    if (rdq.size() != 0) errors++;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  task automatic note(input int off, input int sel, input logic [31:0] m, input logic [31:0] e);
    tq.push_back('{base + off, sel, m, e});
  endtask : note

  // Master holds each phase until hready is seen high at a rising edge
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= iflow_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge clock); while (hreadyout !== 1'b1);
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rdq.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask : rd

  // Literal and register operands differ so a wrong source shows up
  task automatic go(input iflow_pkg::iflow_iclass_t ic, input logic [15:0] arg,
                    input logic program_space_visibility, input logic dep, input logic exc);
    logic [13:0] lit;
    logic [15:0] wreg;
    lit = (ic == iflow_pkg::IC_REPEAT_REG) ? ~arg[13:0] : arg[13:0];
    wreg = (ic == iflow_pkg::IC_REPEAT_LIT) ? ~arg : arg;
    @(posedge clock);
    base = cyc;
    dec <= '{valid: 1'b1, iclass: ic, literal: lit, work_reg: wreg, psv_read: program_space_visibility,
      addr_dep: dep};
    exc_entry <= exc;
    @(posedge clock);
    dec.valid <= 1'b0;
    exc_entry <= 1'b0;
  endtask : go

  task automatic run_loop(input iflow_pkg::iflow_iclass_t ic, input logic [15:0] arg);
    int n;
    n = int'(arg[13:0]);
    go(ic, arg, 1'b0, 1'b0, 1'b0);
    note(2, 1, CM, 32'(n));
    note(2, 2, 1, 32'(n != 0));
    if (n == 0) note(2, 0, NP, NP);
    for (int k = n; k >= 0; k--) begin
      go(iflow_pkg::IC_NORMAL, 16'h0, 1'b0, 1'b0, 1'b0);
      note(2, 1, CM, 32'(k > 0 ? k - 1 : 0));
      note(2, 2, 1, 32'(k > 1));
      note(2, 0, PI, k > 0 ? 32'h0 : PI);
    end
    $display("test repeat %0d done", n);
  endtask : run_loop

  // ------
  // Monitors and timeout
  // ------
  always @(negedge clock) begin : timed_monitor
    logic [31:0] seen;
    cyc++;
    for (int i = tq.size() - 1; i >= 0; i--) begin
      if (tq[i].cyc == cyc) begin
        case (tq[i].sel)
          0: seen = 32'(ctl);
          1: seen = 32'(repeat_loop_count);
          2: seen = 32'(repeat_active_flag);
          default: seen = 32'(stacked_status);
        endcase
        check(names[tq[i].sel], seen & tq[i].mask, tq[i].exp);
        tq.delete(i);
      end
    end
  end

  always @(posedge clock) begin : bus_monitor
    if (rd_pend && hreadyout === 1'b1 && rdq.size() > 0) begin
      check("hrdata", hrdata, rdq.pop_front());
      check("hresp", 32'(hresp), 32'(iflow_pkg::HRESP_OKAY));
    end
    if (hreadyout === 1'b1) rd_pend <= hsel && htrans == iflow_pkg::HTRANS_NONSEQ && !hwrite;
  end

  // Longest run is the full fourteen-bit loop, about 33k cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      $display("mismatch timeout expected %0d seen %0d", 0, cycles);
      end_of_test();
    end
  end

  initial begin : main
    dec = '0;
    exc_entry = 1'b0;
    stack_status_in = 8'h00;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    reset_n = 1'b0;
    void'($urandom(32'hcec9a4b9));
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(iflow_pkg::ADDR_REPEAT_COUNT, 32'h0);
    rd(iflow_pkg::ADDR_STATUS_LOW, 32'h0);
    rd(iflow_pkg::ADDR_FLOW_STATUS, 32'h0);
    rd(8'h0c, 32'h0);
    r = $urandom;
    bus(iflow_pkg::ADDR_REPEAT_COUNT, 1'b1, r);
    rd(iflow_pkg::ADDR_REPEAT_COUNT, r & CM);
    bus(iflow_pkg::ADDR_STATUS_LOW, 1'b1, 32'hff);
    rd(iflow_pkg::ADDR_STATUS_LOW, 32'hef);
    bus(iflow_pkg::ADDR_REPEAT_COUNT, 1'b1, 32'h0);
    $display("test registers done");
    foreach (rets[i]) begin
      go(rets[i], 16'h0, 1'b0, 1'b0, 1'b0);
      note(2, 0, FL | BZ | FE, FL | BZ);
      note(3, 0, BZ | FE | PI, BZ | FE | PI);
      note(4, 0, BZ, 32'h0);
      repeat (2) @(posedge clock);
    end
    go(iflow_pkg::IC_TABLE, 16'h0, 1'b0, 1'b0, 1'b0);
    note(2, 0, PM | HO | FE | BZ, PM | HO | BZ);
    note(3, 0, BZ | FE, FE);
    go(iflow_pkg::IC_TWO_WORD, 16'h0, 1'b0, 1'b0, 1'b0);
    note(2, 0, BZ | FE, BZ | FE);
    note(3, 0, BZ, 32'h0);
    go(iflow_pkg::IC_SECOND_WORD, 16'h0, 1'b0, 1'b0, 1'b0);
    note(2, 0, NP, NP);
    go(iflow_pkg::IC_NORMAL, 16'h0, 1'b0, 1'b1, 1'b0);
    note(2, 0, ST | BZ | FE, ST | BZ);
    note(3, 0, ST, 32'h0);
    $display("test flow types done");
    run_loop(iflow_pkg::IC_REPEAT_LIT, 16'h0002);
    r = $urandom;
    run_loop(iflow_pkg::IC_REPEAT_REG, {r[15:14], 12'h0, r[1:0]});
    run_loop(iflow_pkg::IC_REPEAT_LIT, 16'h0000);
    run_loop(iflow_pkg::IC_REPEAT_LIT, 16'h3fff);
    go(iflow_pkg::IC_REPEAT_LIT, 16'h0003, 1'b0, 1'b0, 1'b0);
    go(iflow_pkg::IC_NORMAL, 16'h0, 1'b0, 1'b0, 1'b0);
    bus(iflow_pkg::ADDR_STATUS_LOW, 1'b1, 32'h0);
    rd(iflow_pkg::ADDR_FLOW_STATUS, 32'h1);
    go(iflow_pkg::IC_NORMAL, 16'h0, 1'b0, 1'b0, 1'b1);
    note(2, 3, 32'h10, 32'h10);
    note(2, 2, 1, 32'h0);
    note(2, 1, CM, 32'h2);
    stack_status_in <= 8'h10;
    // No repeat inside the service routine, so the count needs no save
    go(iflow_pkg::IC_NORMAL, 16'h0, 1'b0, 1'b0, 1'b0);
    note(2, 0, PI, PI);
    go(iflow_pkg::IC_INT_RETURN, 16'h0, 1'b0, 1'b0, 1'b0);
    note(4, 2, 1, 32'h1);
    repeat (2) @(posedge clock);
    go(iflow_pkg::IC_NORMAL, 16'h0, 1'b1, 1'b0, 1'b0);
    note(2, 0, ST | BZ, ST | BZ);
    note(2, 1, CM, 32'h1);
    go(iflow_pkg::IC_NORMAL, 16'h0, 1'b1, 1'b0, 1'b0);
    note(2, 0, ST | PI, 32'h0);
    go(iflow_pkg::IC_NORMAL, 16'h0, 1'b1, 1'b0, 1'b0);
    note(2, 0, PI, PI);
    $display("test interrupted loop done");
    go(iflow_pkg::IC_REPEAT_LIT, 16'h0004, 1'b0, 1'b0, 1'b0);
    go(iflow_pkg::IC_NORMAL, 16'h0, 1'b0, 1'b0, 1'b0);
    go(iflow_pkg::IC_NORMAL, 16'h0, 1'b0, 1'b0, 1'b1);
    note(2, 3, 32'h10, 32'h10);
    bus(iflow_pkg::ADDR_REPEAT_COUNT, 1'b1, 32'h0);
    go(iflow_pkg::IC_INT_RETURN, 16'h0, 1'b0, 1'b0, 1'b0);
    note(4, 2, 1, 32'h0);
    repeat (2) @(posedge clock);
    go(iflow_pkg::IC_NORMAL, 16'h0, 1'b0, 1'b0, 1'b0);
    note(2, 0, PI, PI);
    repeat (4) @(posedge clock);
    $display("test early end done");
    end_of_test();
  end
endmodule : instruction_flow_repeat_loop_tb
